// [hw/ecc_event_if.sv]
// carrier for correction and recorded error events between the bank and its counter and capture leaves
// assumes all three parties share one clock
`timescale 1ns/10ps
interface ecc_event_if;
  import vcr_pkg::*;
  logic corr_event;
  logic record_event;
  logic [FAIL_W-1:0] chunk_addr;
  logic [CNT_W-1:0] count;
  logic [FAIL_W-1:0] first_addr;
  logic first_valid;
  modport hub (output corr_event, output record_event, output chunk_addr,
               input count, input first_addr, input first_valid);
  modport counter (input corr_event, output count);
  modport capture (input record_event, input chunk_addr, output first_addr,
                   output first_valid);
endinterface : ecc_event_if

// [hw/event_counter.sv]
// saturating count of correction events
// assumes events are qualified by the bank before they arrive
`timescale 1ns/10ps
module event_counter
  import vcr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // events
  ecc_event_if.counter ev
);

  // sticks at the top so software can tell overflow happened
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ev.count <= '0;
    end else if (ev.corr_event && (ev.count != COUNT_MAX)) begin
      ev.count <= ev.count + 1'b1; // R17
    end
  end

endmodule : event_counter

// [hw/fail_capture.sv]
// holds the chunk address of the first recorded error event
// assumes record_event is already filtered by error type and ecc state
`timescale 1ns/10ps
module fail_capture
  import vcr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // events
  ecc_event_if.capture ev
);

  // only the first event is kept; later ones are dropped until reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ev.first_valid <= 1'b0;
      ev.first_addr <= '0;
    end else if (ev.record_event && !ev.first_valid) begin
      ev.first_valid <= 1'b1; // R5
      ev.first_addr <= ev.chunk_addr;
    end
  end

endmodule : fail_capture

// [hw/vcr_bank.sv]
// volatile configuration register bank with decoded settings and ecc status
// assumes one-cycle register command strobes and a cmd_start pulse per flash command
//
// Contract
// R1: bit 6 of 0Bh at 0 inverts training line 3, at 1 all lines equal.
// R2: bits 5:4 of 0Bh pick chunk 16/32/64/128 bytes for codes 11/10/01/00.
// R3: bit 3 of 0Bh at 0 enables parity and data checks, octal DDR only.
// R4: bit 2 of 0Bh picks 2-bit detection (1) or 1-bit correction (0) for error pin.
// R5: error type also picks what the first fail address records, only with ecc on.
// R6: bit 1 of 0Bh at 0 enables the error pin; default keeps it inactive.
// R7: bit 0 of 0Bh at 0 turns correction on; resets to 1, off.
// R8: 0Ah holds the training pattern, default 55h, bit 7 most significant.
// R9: 07h wrap: FFh continuous, FEh 64, FDh 32, FCh 16 bytes; rest reserved.
// R10: 06h at FEh enables execute in place; host enables before entering.
// R11: 05h FFh gives 3 address bytes, FEh gives 4; rest reserved.
// R12: 03h drive code FFh 50, FEh 35, FDh 25, FCh 18 ohm; rest reserved.
// R13: 01h dummy count 01h-1Eh literal, 1Fh per-command default, 00h like 1Fh.
// R14: host programs enough dummy cycles for its clock rate.
// R15: 00h protocol FFh, DFh, E7h, C7h; everything else reserved.
// R16: DDR x8 strapped parts read FFh yet only accept octal DDR with strobe.
// R17: correction counter in 0Ch bits 6:3 counts events and saturates at 15.
// R18: writes of reserved settings are ignored, set flag bit 1, clear latch.
// R19: reads of reserved addresses return FFh.
// R20: only the low address byte selects a register byte.
// R21: all bits reset to FFh unless a field gives another default.
// R22: new settings apply from the next command after the write.
`timescale 1ns/10ps
module vcr_bank
  import vcr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // strap, sampled once after reset
  input wire logic boot_ddr8,
  // register command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [31:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rd_valid_r,
  output logic [7:0] rd_data_r,
  output logic wr_accept_r,
  // flag status and write enable latch side effects
  input wire logic flag_clear,
  output logic reserved_flag_r,
  output logic wel_clear_r,
  // command boundary
  input wire logic cmd_start,
  // applied settings
  output logic io_ddr_r,
  output logic io_strobe_r,
  output logic [DUMMY_W-1:0] dummy_cycles_r,
  output logic dummy_default_r,
  output logic [1:0] drive_code_r,
  output logic addr_4byte_r,
  output logic exec_in_place_en_r,
  output logic [6:0] wrap_bytes_r,
  output logic [7:0] chunk_bytes_r,
  output logic integrity_check_on_r,
  output logic correction_on_r,
  // training pattern drive
  input wire logic [2:0] train_bit_sel,
  output logic [7:0] train_dq_r,
  // ecc events from the array path
  input wire logic ecc_corr_event,
  input wire logic ecc_detect_event,
  input wire logic [FAIL_W-1:0] ecc_chunk_addr,
  output logic err_n_r
);

  // ************************************************************
  // storage
  // ************************************************************
  logic [7:0] mode_r;
  logic [7:0] dummy_r;
  logic [7:0] drive_r;
  logic [7:0] addr_bytes_r;
  logic [7:0] exec_r;
  logic [7:0] wrap_r;
  logic [7:0] train_r;
  logic [6:0] integ_r;
  logic [6:0] act_integ_r;
  logic [7:0] act_train_r;
  logic strap_r;
  logic strap_done_r;
  logic detect_stat_r;
  logic [7:0] rd_nxt;
  logic [7:0] lsb;
  logic write_hit;
  logic write_good;
  logic read_hit;
  ecc_event_if ev ();

  // legal-code check per register; strapped parts refuse the extended modes
  function automatic logic write_ok(input logic [7:0] a, input logic [7:0] d,
                                    input logic strap);
    if (a == OFS_IO_MODE) begin
      if (strap) begin
        return d == IO_ODDR_STROBE;
      end
      return (d == IO_EXT_STROBE) || (d == IO_EXT_NO_STROBE) ||
             (d == IO_ODDR_STROBE) || (d == IO_ODDR_NO_STROBE);
    end else if (a == OFS_DUMMY) begin
      return d <= DUMMY_DEF;
    end else if ((a == OFS_DRIVE) || (a == OFS_WRAP)) begin
      return (d == CODE_0) || (d == CODE_1) || (d == CODE_2) || (d == CODE_3);
    end else if ((a == OFS_ADDR_BYTES) || (a == OFS_EXEC_IN_PLACE)) begin
      return (d == CODE_0) || (d == CODE_1);
    end else if ((a == OFS_TRAIN) || (a == OFS_INTEG)) begin
      return 1'b1;
    end
    return 1'b0;
  endfunction : write_ok

  // index of a four-way code FFh..FCh, 0 for FFh
  function automatic logic [1:0] code_index(input logic [7:0] d);
    return ~d[1:0];
  endfunction : code_index

  // ************************************************************
  // command decode
  // ************************************************************
  assign lsb = cmd_addr[7:0]; // R20
  assign write_hit = cmd_valid && cmd_write;
  assign read_hit = cmd_valid && !cmd_write;
  assign write_good = write_ok(lsb, cmd_wdata, strap_r);

  // strap is caught by the clock after release, never by the reset itself
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_r <= boot_ddr8;
      strap_done_r <= 1'b1;
    end
  end

  // ************************************************************
  // register writes
  // ************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r <= RST_ERASED; // R21 R16
      dummy_r <= RST_DUMMY;
      drive_r <= RST_ERASED;
      addr_bytes_r <= RST_ERASED;
      exec_r <= RST_ERASED;
      wrap_r <= RST_ERASED;
      train_r <= RST_TRAIN; // R8
      integ_r <= RST_INTEG; // R7
    end else if (write_hit && write_good) begin
      if (lsb == OFS_IO_MODE) begin
        mode_r <= cmd_wdata; // R15
      end else if (lsb == OFS_DUMMY) begin
        dummy_r <= cmd_wdata; // R13
      end else if (lsb == OFS_DRIVE) begin
        drive_r <= cmd_wdata; // R12
      end else if (lsb == OFS_ADDR_BYTES) begin
        addr_bytes_r <= cmd_wdata; // R11
      end else if (lsb == OFS_EXEC_IN_PLACE) begin
        exec_r <= cmd_wdata; // R10
      end else if (lsb == OFS_WRAP) begin
        wrap_r <= cmd_wdata; // R9
      end else if (lsb == OFS_TRAIN) begin
        train_r <= cmd_wdata; // R8
      end else if (lsb == OFS_INTEG) begin
        integ_r <= cmd_wdata[6:0];
      end
    end
  end

  // refusal side effects; a new refusal wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reserved_flag_r <= 1'b0;
      wel_clear_r <= 1'b0;
      wr_accept_r <= 1'b0;
    end else begin
      wel_clear_r <= write_hit && !write_good; // R18
      wr_accept_r <= write_hit && write_good;
      if (write_hit && !write_good) begin
        reserved_flag_r <= 1'b1; // R18
      end else if (flag_clear) begin
        reserved_flag_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // register reads
  // ************************************************************
  // read mux; unmapped bytes answer erased
  always_comb begin
    rd_nxt = READ_RESERVED; // R19
    if (lsb == OFS_IO_MODE) begin
      rd_nxt = mode_r;
    end else if (lsb == OFS_DUMMY) begin
      rd_nxt = dummy_r;
    end else if (lsb == OFS_DRIVE) begin
      rd_nxt = drive_r;
    end else if (lsb == OFS_ADDR_BYTES) begin
      rd_nxt = addr_bytes_r;
    end else if (lsb == OFS_EXEC_IN_PLACE) begin
      rd_nxt = exec_r;
    end else if (lsb == OFS_WRAP) begin
      rd_nxt = wrap_r;
    end else if (lsb == OFS_TRAIN) begin
      rd_nxt = train_r;
    end else if (lsb == OFS_INTEG) begin
      rd_nxt = {1'b1, integ_r}; // reserved top bit reads erased
    end else if (lsb == OFS_ECC_STAT) begin
      rd_nxt = {1'b0, ev.count, detect_stat_r, 2'b00}; // R17
    end else if (lsb == OFS_FAIL0) begin
      rd_nxt = {ev.first_addr[3:0], 4'h0};
    end else if (lsb == OFS_FAIL1) begin
      rd_nxt = ev.first_addr[11:4];
    end else if (lsb == OFS_FAIL2) begin
      rd_nxt = ev.first_addr[19:12];
    end else if (lsb == OFS_FAIL3) begin
      rd_nxt = ev.first_addr[27:20];
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_valid_r <= read_hit;
      rd_data_r <= read_hit ? rd_nxt : rd_data_r;
    end
  end

  // ************************************************************
  // settings applied at command boundaries
  // ************************************************************
  // a command in flight keeps its old view; costs one cycle of latency at start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      io_ddr_r <= 1'b0;
      io_strobe_r <= 1'b1;
      dummy_cycles_r <= RST_DUMMY[DUMMY_W-1:0];
      dummy_default_r <= 1'b1;
      drive_code_r <= 2'b00;
      addr_4byte_r <= 1'b0;
      exec_in_place_en_r <= 1'b0;
      wrap_bytes_r <= WRAP_NONE;
      act_integ_r <= RST_INTEG;
      act_train_r <= RST_TRAIN;
    end else if (cmd_start) begin // R22
      io_ddr_r <= strap_r || (mode_r == IO_ODDR_STROBE) ||
                  (mode_r == IO_ODDR_NO_STROBE); // R15 R16
      io_strobe_r <= strap_r || (mode_r == IO_EXT_STROBE) ||
                     (mode_r == IO_ODDR_STROBE);
      dummy_cycles_r <= dummy_r[DUMMY_W-1:0];
      dummy_default_r <= (dummy_r == DUMMY_DEF) || (dummy_r == DUMMY_ZERO); // R13
      drive_code_r <= code_index(drive_r); // R12
      addr_4byte_r <= addr_bytes_r == CODE_1; // R11
      exec_in_place_en_r <= exec_r == CODE_1; // R10
      case (code_index(wrap_r)) // R9
        2'b01: wrap_bytes_r <= WRAP_64;
        2'b10: wrap_bytes_r <= WRAP_32;
        2'b11: wrap_bytes_r <= WRAP_16;
        default: wrap_bytes_r <= WRAP_NONE;
      endcase
      act_integ_r <= integ_r;
      act_train_r <= train_r;
    end
  end

  // integrity decode follows the applied control byte and mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chunk_bytes_r <= CHUNK_16;
      integrity_check_on_r <= 1'b0;
      correction_on_r <= 1'b0;
    end else begin
      case (act_integ_r[CHUNK_HI:CHUNK_LO]) // R2
        2'b11: chunk_bytes_r <= CHUNK_16;
        2'b10: chunk_bytes_r <= CHUNK_32;
        2'b01: chunk_bytes_r <= CHUNK_64;
        default: chunk_bytes_r <= CHUNK_128;
      endcase
      integrity_check_on_r <= !act_integ_r[BIT_CHECK] && io_ddr_r; // R3
      correction_on_r <= !act_integ_r[BIT_ECC]; // R7
    end
  end

  // training lines; line 3 flips when the select bit is clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      train_dq_r <= '0;
    end else begin
      train_dq_r <= {8{act_train_r[train_bit_sel]}} ^
                    (act_integ_r[BIT_TRAIN_SEL] ? 8'h00 : LINE3_MASK); // R1
    end
  end

  // ************************************************************
  // ecc events, error pin and status
  // ************************************************************
  assign ev.corr_event = ecc_corr_event && correction_on_r;
  assign ev.record_event = correction_on_r &&
                           (act_integ_r[BIT_ERR_TYPE] ? ecc_detect_event : ecc_corr_event); // R5
  assign ev.chunk_addr = ecc_chunk_addr;

  // pin is low for one cycle per selected event, only while enabled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_n_r <= 1'b1;
      detect_stat_r <= 1'b0;
    end else begin
      err_n_r <= !(ev.record_event && !act_integ_r[BIT_ERR_PIN]); // R4 R6
      if (ecc_detect_event && correction_on_r) begin
        detect_stat_r <= 1'b1;
      end
    end
  end

  event_counter u_count (
    .clock(clock),
    .rst(rst),
    .ev(ev.counter)
  );

  fail_capture u_capture (
    .clock(clock),
    .rst(rst),
    .ev(ev.capture)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  flag_set_a: assert property (write_hit && !write_good |=> reserved_flag_r && wel_clear_r) // R18
    else $error("refused write did not flag");
  reject_keep_a: assert property (write_hit && !write_good |=> $stable({wrap_r, mode_r})) // R18
    else $error("refused write changed storage");
  read_reserved_a: assert property (read_hit && (lsb == 8'h02 || lsb == 8'h04 || lsb > OFS_FAIL3)
    |=> rd_valid_r && rd_data_r == READ_RESERVED) // R19
    else $error("reserved read not erased");
  low_byte_a: assert property (read_hit && lsb == OFS_TRAIN |=> rd_data_r == $past(train_r)) // R20
    else $error("low byte select failed");
  apply_hold_a: assert property (!cmd_start |=> $stable({wrap_bytes_r, addr_4byte_r})) // R22
    else $error("setting changed mid command");
  wrap_decode_a: assert property (cmd_start && wrap_r == CODE_1 |=> wrap_bytes_r == WRAP_64) // R9
    else $error("wrap decode wrong");
  chunk_decode_a: assert property (cmd_start && integ_r[CHUNK_HI:CHUNK_LO] == 2'b00
    |=> ##1 chunk_bytes_r == CHUNK_128) // R2
    else $error("chunk decode wrong");
  count_sat_a: assert property (ev.count == COUNT_MAX |=> ev.count == COUNT_MAX) // R17
    else $error("counter left saturation");
  pin_quiet_a: assert property (act_integ_r[BIT_ERR_PIN] |=> err_n_r) // R6
    else $error("error pin active while disabled");
  pin_corr_a: assert property (correction_on_r && !act_integ_r[BIT_ERR_PIN] &&
    !act_integ_r[BIT_ERR_TYPE] && ecc_corr_event |=> !err_n_r) // R4
    else $error("correction did not drive pin");
  check_ddr_a: assert property (!io_ddr_r ##1 !io_ddr_r |-> !integrity_check_on_r) // R3
    else $error("checks on outside octal ddr");
  strap_mode_a: assert property (strap_r && strap_done_r && write_hit && lsb == OFS_IO_MODE &&
    cmd_wdata != IO_ODDR_STROBE |=> reserved_flag_r) // R16
    else $error("strapped part accepted extended mode");

  refuse_c: cover property (write_hit && !write_good ##1 reserved_flag_r);
  apply_c: cover property (wr_accept_r ##[1:4] cmd_start);
  sat_c: cover property (ev.count == COUNT_MAX && ev.corr_event);
  pin_c: cover property (!err_n_r);

endmodule : vcr_bank

// [hw/vcr_pkg.sv]
// volatile configuration bank constants: offsets, reset values, codes, field positions
// assumes every user imports the whole package
package vcr_pkg;

  // ************************************************************
  // register offsets (low address byte only)
  // ************************************************************
  localparam logic [7:0] OFS_IO_MODE = 8'h00;
  localparam logic [7:0] OFS_DUMMY = 8'h01;
  localparam logic [7:0] OFS_DRIVE = 8'h03;
  localparam logic [7:0] OFS_ADDR_BYTES = 8'h05;
  localparam logic [7:0] OFS_EXEC_IN_PLACE = 8'h06;
  localparam logic [7:0] OFS_WRAP = 8'h07;
  localparam logic [7:0] OFS_TRAIN = 8'h0a;
  localparam logic [7:0] OFS_INTEG = 8'h0b;
  localparam logic [7:0] OFS_ECC_STAT = 8'h0c;
  localparam logic [7:0] OFS_FAIL0 = 8'h0d;
  localparam logic [7:0] OFS_FAIL1 = 8'h0e;
  localparam logic [7:0] OFS_FAIL2 = 8'h0f;
  localparam logic [7:0] OFS_FAIL3 = 8'h10;

  // ************************************************************
  // reset values and fixed read answers
  // ************************************************************
  localparam logic [7:0] RST_ERASED = 8'hff;
  localparam logic [7:0] RST_DUMMY = 8'h1f;
  localparam logic [7:0] RST_TRAIN = 8'h55;
  localparam logic [6:0] RST_INTEG = 7'h7f;
  localparam logic [7:0] READ_RESERVED = 8'hff;

  // ************************************************************
  // setting codes
  // ************************************************************
  localparam logic [7:0] IO_EXT_STROBE = 8'hff;
  localparam logic [7:0] IO_EXT_NO_STROBE = 8'hdf;
  localparam logic [7:0] IO_ODDR_STROBE = 8'he7;
  localparam logic [7:0] IO_ODDR_NO_STROBE = 8'hc7;
  localparam logic [7:0] CODE_0 = 8'hff;
  localparam logic [7:0] CODE_1 = 8'hfe;
  localparam logic [7:0] CODE_2 = 8'hfd;
  localparam logic [7:0] CODE_3 = 8'hfc;
  localparam logic [7:0] DUMMY_ZERO = 8'h00;
  localparam logic [7:0] DUMMY_DEF = 8'h1f;

  // ************************************************************
  // field layout of the integrity control byte and status byte
  // ************************************************************
  localparam int BIT_TRAIN_SEL = 6;
  localparam int CHUNK_HI = 5;
  localparam int CHUNK_LO = 4;
  localparam int BIT_CHECK = 3;
  localparam int BIT_ERR_TYPE = 2;
  localparam int BIT_ERR_PIN = 1;
  localparam int BIT_ECC = 0;
  localparam logic [7:0] LINE3_MASK = 8'h08;
  localparam int DUMMY_W = 5;
  localparam int CNT_W = 4;
  localparam int FAIL_W = 28;
  localparam logic [CNT_W-1:0] COUNT_MAX = 4'hf;

  // ************************************************************
  // decoded sizes in bytes
  // ************************************************************
  localparam logic [7:0] CHUNK_16 = 8'h10;
  localparam logic [7:0] CHUNK_32 = 8'h20;
  localparam logic [7:0] CHUNK_64 = 8'h40;
  localparam logic [7:0] CHUNK_128 = 8'h80;
  localparam logic [6:0] WRAP_NONE = 7'h00;
  localparam logic [6:0] WRAP_64 = 7'h40;
  localparam logic [6:0] WRAP_32 = 7'h20;
  localparam logic [6:0] WRAP_16 = 7'h10;

endpackage : vcr_pkg

// [verif/host_cmd_model.sv]
// host controller model: issues one register command at a time
// assumes the bank takes a command on the rising edge and answers one cycle later
`timescale 1ns/10ps
module host_cmd_model
  import vcr_pkg::*;
(
  // clock
  input wire logic clock,
  // command side
  output logic cmd_valid,
  output logic cmd_write,
  output logic [31:0] cmd_addr,
  output logic [7:0] cmd_wdata,
  // answer side
  input wire logic rd_valid_r,
  input wire logic [7:0] rd_data_r,
  input wire logic wr_accept_r,
  input wire logic wel_clear_r
);
  // ************************************************************
  // command cycle
  // ************************************************************
  logic [23:0] upper;
  // idle bus starts at a known level
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 32'h00000000;
    cmd_wdata = 8'h00;
    upper = 24'h5a3c96;
  end
  // call 1 ns after an edge; a trailing idle cycle keeps strobes apart
  task automatic reg_cmd(input logic wr, input logic [7:0] ofs, input logic [7:0] wd,
                         output logic [7:0] rd, output logic [2:0] ans);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = {upper, ofs};
    cmd_wdata = wd;
    @(posedge clock) #1 ans = {rd_valid_r, wr_accept_r, wel_clear_r};
    rd = rd_data_r;
    cmd_valid = 1'b0;
    // released lines show the inverse so stale values cannot pass
    cmd_addr = ~cmd_addr;
    cmd_wdata = ~cmd_wdata;
    upper = {upper[22:0], upper[23] ^ upper[18]}; // upper bytes differ each command
    @(posedge clock) #1;
  endtask : reg_cmd
endmodule : host_cmd_model

// [verif/tb_octal_flash_volatile_config_regs.sv]
// self-checking bench for the volatile configuration bank
// assumes the host model drives the command port; all else driven here
`timescale 1ns/10ps
module tb_octal_flash_volatile_config_regs
  import vcr_pkg::*;
;
  // ************************************************************
  // signals and instances
  // ************************************************************
  typedef struct packed {logic [7:0] ofs; logic [7:0] wd; logic ok; logic [7:0] rd;} row_t;
  logic clock, rst, boot_ddr8, cmd_valid, cmd_write, flag_clear, cmd_start;
  logic rd_valid_r, wr_accept_r, reserved_flag_r, wel_clear_r, io_ddr_r, io_strobe_r;
  logic dummy_default_r, addr_4byte_r, exec_in_place_en_r, integrity_check_on_r;
  logic correction_on_r, ecc_corr_event, ecc_detect_event, err_n_r;
  logic [31:0] cmd_addr;
  logic [7:0] cmd_wdata, rd_data_r, train_dq_r, chunk_bytes_r, rd;
  logic [DUMMY_W-1:0] dummy_cycles_r;
  logic [1:0] drive_code_r;
  logic [6:0] wrap_bytes_r;
  logic [2:0] train_bit_sel, ans;
  logic [FAIL_W-1:0] ecc_chunk_addr;
  int mismatches, cmp_count;
  logic [7:0] dofs [11] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h0b, 8'h02,
                            8'h12, 8'h0c};
  logic [7:0] dval [11] = '{8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h55, 8'hff, 8'hff,
                            8'hff, 8'h00};
  // offset, data, accepted, read back; a refused write keeps the last value
  row_t rows [26] = '{
    '{8'h07, 8'hfe, 1'b1, 8'hfe}, '{8'h07, 8'hfd, 1'b1, 8'hfd}, '{8'h07, 8'hfc, 1'b1, 8'hfc},
    '{8'h07, 8'h00, 1'b0, 8'hfc}, '{8'h07, 8'hfe, 1'b1, 8'hfe}, '{8'h06, 8'h12, 1'b0, 8'hff},
    '{8'h06, 8'hfe, 1'b1, 8'hfe}, '{8'h05, 8'hfd, 1'b0, 8'hff}, '{8'h05, 8'hfe, 1'b1, 8'hfe},
    '{8'h03, 8'hfe, 1'b1, 8'hfe}, '{8'h03, 8'hfd, 1'b1, 8'hfd}, '{8'h03, 8'h10, 1'b0, 8'hfd},
    '{8'h03, 8'hfc, 1'b1, 8'hfc}, '{8'h01, 8'h20, 1'b0, 8'h1f}, '{8'h01, 8'h1e, 1'b1, 8'h1e},
    '{8'h01, 8'h1f, 1'b1, 8'h1f}, '{8'h01, 8'h00, 1'b1, 8'h00}, '{8'h00, 8'hff, 1'b1, 8'hff},
    '{8'h00, 8'hdf, 1'b1, 8'hdf}, '{8'h00, 8'hc7, 1'b1, 8'hc7}, '{8'h00, 8'h7f, 1'b0, 8'hc7},
    '{8'h00, 8'he7, 1'b1, 8'he7}, '{8'h0a, 8'h3c, 1'b1, 8'h3c}, '{8'h0b, 8'h00, 1'b1, 8'h80},
    '{8'h02, 8'h55, 1'b0, 8'hff}, '{8'h0c, 8'h00, 1'b0, 8'h00}};
  vcr_bank i_vcr_bank (.clock(clock), .rst(rst), .boot_ddr8(boot_ddr8), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_valid_r(rd_valid_r),
    .rd_data_r(rd_data_r), .wr_accept_r(wr_accept_r), .flag_clear(flag_clear),
    .reserved_flag_r(reserved_flag_r), .wel_clear_r(wel_clear_r), .cmd_start(cmd_start),
    .io_ddr_r(io_ddr_r), .io_strobe_r(io_strobe_r), .dummy_cycles_r(dummy_cycles_r),
    .dummy_default_r(dummy_default_r), .drive_code_r(drive_code_r),
    .addr_4byte_r(addr_4byte_r), .exec_in_place_en_r(exec_in_place_en_r),
    .wrap_bytes_r(wrap_bytes_r), .chunk_bytes_r(chunk_bytes_r),
    .integrity_check_on_r(integrity_check_on_r), .correction_on_r(correction_on_r),
    .train_bit_sel(train_bit_sel), .train_dq_r(train_dq_r), .ecc_corr_event(ecc_corr_event),
    .ecc_detect_event(ecc_detect_event), .ecc_chunk_addr(ecc_chunk_addr), .err_n_r(err_n_r));
  host_cmd_model i_host_cmd_model (.clock(clock), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .wr_accept_r(wr_accept_r),
    .wel_clear_r(wel_clear_r));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk
  // settings latch on a command boundary; the integrity decode needs a second cycle
  task automatic start_cmd;
    cmd_start = 1'b1;
    @(posedge clock) #1 cmd_start = 1'b0;
    repeat (2) @(posedge clock) #1;
  endtask : start_cmd
  task automatic ecc_pulse(input logic det, input logic [FAIL_W-1:0] a, input logic exp_n);
    ecc_corr_event = !det;
    ecc_detect_event = det;
    ecc_chunk_addr = a;
    @(posedge clock) #1 chk("error pin", exp_n, err_n_r);
    ecc_corr_event = 1'b0;
    ecc_detect_event = 1'b0;
    ecc_chunk_addr = ~a;
    @(posedge clock) #1;
  endtask : ecc_pulse
  task automatic report_and_stop;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // ************************************************************
  // clock, watchdog, sequence
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // whole run needs well under a thousand cycles
  initial begin
    #25000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    mismatches = 0;
    cmp_count = 0;
    rst = 1'b1;
    boot_ddr8 = 1'b0;
    flag_clear = 1'b0;
    cmd_start = 1'b0;
    train_bit_sel = 3'h2;
    ecc_corr_event = 1'b0;
    ecc_detect_event = 1'b0;
    ecc_chunk_addr = '0;
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    @(posedge clock) #1 chk("reset outputs", {8'h61, 5'h1f, 2'h0}, {io_ddr_r, io_strobe_r,
      dummy_default_r, addr_4byte_r, exec_in_place_en_r, integrity_check_on_r,
      correction_on_r, err_n_r, dummy_cycles_r, drive_code_r});
    chk("reset sizes", {WRAP_NONE, CHUNK_16}, {wrap_bytes_r, chunk_bytes_r});
    for (int i = 0; i < 11; i++) begin
      i_host_cmd_model.reg_cmd(1'b0, dofs[i], 8'h00, rd, ans);
      chk("reset read", dval[i], rd);
    end
    // ordinary cases: write, check answer and flag, clear flag, read back
    foreach (rows[i]) begin
      i_host_cmd_model.reg_cmd(1'b1, rows[i].ofs, rows[i].wd, rd, ans);
      chk("write answer", {2'b00, rows[i].ok, !rows[i].ok}, ans);
      chk("refusal flag", !rows[i].ok, reserved_flag_r);
      flag_clear = 1'b1;
      @(posedge clock) #1 flag_clear = 1'b0;
      i_host_cmd_model.reg_cmd(1'b0, rows[i].ofs, 8'h00, rd, ans);
      chk("read back", {3'b100, rows[i].rd}, {ans, rd});
    end
    chk("held wrap", WRAP_NONE, wrap_bytes_r);
    ecc_pulse(1'b0, 28'h0fedcba, 1'b1);
    start_cmd();
    chk("applied flags", 7'h7f, {io_ddr_r, io_strobe_r, dummy_default_r, addr_4byte_r,
      exec_in_place_en_r, integrity_check_on_r, correction_on_r});
    chk("applied sizes", {2'd3, WRAP_64, CHUNK_128}, {drive_code_r, wrap_bytes_r,
      chunk_bytes_r});
    @(posedge clock) #1 chk("train high", 8'hff ^ LINE3_MASK, train_dq_r);
    train_bit_sel = 3'h0;
    @(posedge clock) #1 chk("train low", 8'h00 ^ LINE3_MASK, train_dq_r);
    for (int k = 0; k < 17; k++) begin
      ecc_pulse(1'b0, 28'h1234567 + k, 1'b0);
    end
    ecc_pulse(1'b1, 28'h0abcdef, 1'b1);
    for (int i = 0; i < 5; i++) begin
      i_host_cmd_model.reg_cmd(1'b0, 8'h0c + i, 8'h00, rd, ans);
      chk("ecc status", (i == 0) ? 32'h7c : 32'h12345670 >> ((i - 1) * 8) & 32'hff, rd);
    end
    boot_ddr8 = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    @(posedge clock) #1 i_host_cmd_model.reg_cmd(1'b0, 8'h00, 8'h00, rd, ans);
    chk("strap read", 8'hff, rd);
    i_host_cmd_model.reg_cmd(1'b1, 8'h00, 8'hdf, rd, ans);
    chk("strap refuse", 3'b001, ans);
    i_host_cmd_model.reg_cmd(1'b1, 8'h00, 8'he7, rd, ans);
    chk("strap accept", 3'b010, ans);
    start_cmd();
    chk("strap mode", 2'b11, {io_ddr_r, io_strobe_r});
    report_and_stop();
  end
endmodule : tb_octal_flash_volatile_config_regs
